//--- verilog/ubt_pkg.sv
// Behaviour
// - Token to a buffer whose ready bit is clear gets a NAK.
// - Endpoint direction bit decides whether a buffer serves IN or OUT.
// - Endpoint 0 has one buffer and one ready bit for both directions.
// - Ready bits 0-7 buffer 0, 9-15 buffer 1; bit 8, 31-16 zero.
// - Three-bit test-mode field: normal, J, K, NAK, packet; resets normal.
// - Continuous-J mode drives chirp J without break until the mode is rewritten or reset.
// - Continuous-K mode drives chirp K without break until the mode is rewritten or reset.
// - NAK test mode NAKs IN tokens with good CRC, ignores bad ones.
// - Test-packet mode sends packet from fixed RAM sequence, repeating until mode changes.
// - Error register holds stuff, PID and CRC 8-bit counters; 31-24 reserved.
// - Counters clear on USB bus reset and on software read.
// - Seven-ones report bumps stuff counter and raises stuff error flag.
// - PID check bits not complementing PID bump PID counter and flag.
// - CRC mismatch, CRC5 tokens or CRC16 data, bumps CRC counter and flag.
// - A counter at 255 wraps to zero on next increment.
// - Error register is read-only; writes change nothing.
// - Error flags raise interrupt only with own enable and master enable.
package ubt_pkg;
   // Register map, byte addresses
   localparam int UBT_ADDR_W = 12;
   localparam logic [11:0] UBT_RDY_OFS = 12'h114;
   localparam logic [11:0] UBT_MODE_OFS = 12'h118;
   localparam logic [11:0] UBT_CNT_OFS = 12'h11C;
   // Reset values
   localparam logic [15:0] UBT_RDY_RST = 16'h0000;
   localparam logic [2:0] UBT_MODE_RST = 3'h0;
   // Writable ready bits, bit 8 reserved
   localparam logic [15:0] UBT_RDY_MASK = 16'hFEFF;
   localparam int UBT_RDY_W = 16;
   localparam int UBT_MODE_W = 3;
   // Error counter fields
   localparam int UBT_CNT_W = 8;
   localparam int UBT_STUFF_LSB = 16;
   localparam int UBT_PID_LSB = 8;
   localparam int UBT_CRC_LSB = 0;
   localparam int UBT_CRC5_W = 5;
   // Interrupt enable bit positions
   localparam int UBT_EN_MST = 31;
   localparam int UBT_EN_STUFF = 29;
   localparam int UBT_EN_PID = 28;
   localparam int UBT_EN_CRC = 27;
   // Test packet location in packet RAM
   localparam logic [8:0] UBT_TP_BASE = 9'h000;
   localparam int UBT_TP_LEN = 53;
   localparam int UBT_RAM_AW = 9;

   typedef enum logic [2:0] {
      UBT_MODE_NORMAL = 3'h0,
      UBT_MODE_J = 3'h1,
      UBT_MODE_K = 3'h2,
      UBT_MODE_NAK = 3'h3,
      UBT_MODE_PKT = 3'h4
   } ubt_mode_t;

   typedef enum logic [1:0] {
      UBT_TP_IDLE = 2'h0,
      UBT_TP_FETCH = 2'h1,
      UBT_TP_SEND = 2'h3,
      UBT_TP_GAP = 2'h2
   } ubt_tp_state_t;

   // Ready bit index of an endpoint buffer; endpoint 0 always maps to bit 0
   function automatic logic [3:0] ubt_ready_bit(input logic [2:0] ep, input logic buf_sel);
      return (buf_sel && (ep != 3'h0)) ? {1'b1, ep} : {1'b0, ep};
   endfunction

   // Effective mode; undefined codes fall back to normal
   function automatic ubt_mode_t ubt_mode_eff(input logic [2:0] code);
      return (code > 3'h4) ? UBT_MODE_NORMAL : ubt_mode_t'(code);
   endfunction
endpackage

//--- verilog/ubt_err_cnt.sv
`timescale 1ns/10ps
module ubt_err_cnt #(
   parameter int WIDTH = ubt_pkg::UBT_CNT_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clr,
   input wire logic inc,
   output logic [WIDTH-1:0] count
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   // Clear first, then count, so an event in the clearing cycle survives
   // natural wrap
   assign count_d = (clr ? '0 : count_q) + {{(WIDTH-1){1'b0}}, inc};
   assign count = count_q;

   // Counter register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_cnt_wrap_zero: assert property ((count_q == '1) && inc && !clr |=> count_q == '0)
      else $error("Counter did not wrap to zero");
   a_cnt_clear_zero: assert property (clr && !inc |=> count_q == '0)
      else $error("Counter not cleared");
   a_cnt_hold_idle: assert property (!clr && !inc |=> $stable(count_q))
      else $error("Counter changed without cause");
endmodule // ubt_err_cnt

//--- verilog/ubt_bufrdy_test.sv
`timescale 1ns/10ps
module ubt_bufrdy_test #(
   parameter logic [8:0] TP_BASE = ubt_pkg::UBT_TP_BASE,
   parameter int TP_LEN = ubt_pkg::UBT_TP_LEN
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] endpoint_direction_bit,
   input wire logic tok_valid,
   input wire logic tok_is_in,
   input wire logic tok_crc_ok,
   input wire logic [2:0] tok_ep,
   input wire logic tok_buf,
   output logic tok_nak,
   output logic tok_go,
   input wire logic xfer_done,
   input wire logic [2:0] xfer_ep,
   input wire logic xfer_buf,
   input wire logic usb_bus_reset,
   input wire logic stuff_err_evt,
   input wire logic pid_valid,
   input wire logic [7:0] pid_byte,
   input wire logic crc_valid,
   input wire logic crc_is_data,
   input wire logic [15:0] crc_rx,
   input wire logic [15:0] crc_calc,
   output logic stuffing_error_flag,
   output logic packet_id_error_flag,
   output logic checksum_error_flag,
   input wire logic [31:0] interrupt_enable_reg,
   input wire logic [2:0] err_status_bits,
   output logic err_irq,
   output logic chirp_j,
   output logic chirp_k,
   output logic [8:0] pkt_ram_addr,
   output logic pkt_ram_rd,
   input wire logic [7:0] pkt_ram_rdata,
   output logic [7:0] tx_byte,
   output logic tx_valid,
   output logic tx_last,
   input wire logic tx_ready
);
   localparam logic [8:0] TP_LAST = 9'(TP_LEN - 1);

   logic [15:0] rdy_q;
   logic [15:0] rdy_d;
   logic [2:0] tm_q;
   logic [31:0] prdata_q;
   logic nak_q;
   logic go_q;
   logic [2:0] flag_q;
   logic irq_q;
   ubt_pkg::ubt_tp_state_t tp_q;
   ubt_pkg::ubt_tp_state_t tp_d;
   logic [8:0] tp_idx_q;
   logic [8:0] tp_idx_d;
   logic [7:0] tx_byte_q;
   logic [7:0] cnt [3];

   // APB decode
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire hit_rdy = paddr[11:2] == ubt_pkg::UBT_RDY_OFS[11:2];
   wire hit_mode = paddr[11:2] == ubt_pkg::UBT_MODE_OFS[11:2];
   // counter word has no write path
   wire hit_cnt = paddr[11:2] == ubt_pkg::UBT_CNT_OFS[11:2];
   wire hit_any = hit_rdy | hit_mode | hit_cnt;
   wire wr_rdy = access & pwrite & hit_rdy;
   wire wr_mode = access & pwrite & hit_mode;
   wire cnt_rd_clr = setup & ~pwrite & hit_cnt;
   wire cnt_clr = usb_bus_reset | cnt_rd_clr;

   assign pready = 1'b1;
   assign pslverr = access & ~hit_any;

   // Read data; reserved bits read as zero
   wire [31:0] cnt_word = {8'h00, cnt[2], cnt[1], cnt[0]};
   wire [31:0] rd_mux = hit_rdy ? {16'h0000, rdy_q} :
                        hit_mode ? {29'h0, tm_q} :
                        hit_cnt ? cnt_word : 32'h00000000;

   // Mode selection
   // undefined codes run as normal
   ubt_pkg::ubt_mode_t mode;
   assign mode = ubt_pkg::ubt_mode_eff(tm_q);
   wire mode_normal = mode == ubt_pkg::UBT_MODE_NORMAL;
   wire mode_naktest = mode == ubt_pkg::UBT_MODE_NAK;
   wire mode_pkt = mode == ubt_pkg::UBT_MODE_PKT;

   // Token decision
   // endpoint 0 single bit
   wire [3:0] tok_bit = ubt_pkg::ubt_ready_bit(tok_ep, tok_buf);
   wire tok_ready = rdy_q[tok_bit];
   wire dir_ok = (tok_ep == 3'h0) | (endpoint_direction_bit[tok_ep] == tok_is_in);
   wire tok_good = tok_valid & tok_crc_ok;
   // ready and direction needed to proceed
   wire go_d = tok_good & mode_normal & tok_ready & dir_ok;
   // NAK test answers good IN tokens
   wire nak_d = tok_good & ((mode_normal & ~(tok_ready & dir_ok)) | (mode_naktest & tok_is_in));

   // Completion clears the finished buffer's bit
   wire [3:0] done_bit = ubt_pkg::ubt_ready_bit(xfer_ep, xfer_buf);
   wire [15:0] done_mask = xfer_done ? (16'h0001 << done_bit) : 16'h0000;

   // done clears unless firmware writes the same cycle
   assign rdy_d = wr_rdy ? (pwdata[15:0] & ubt_pkg::UBT_RDY_MASK) : (rdy_q & ~done_mask);

   // Ready and test-mode registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdy_q <= ubt_pkg::UBT_RDY_RST;
         tm_q <= ubt_pkg::UBT_MODE_RST;
      end else begin
         rdy_q <= rdy_d;
         if (wr_mode) begin
            tm_q <= pwdata[2:0];
         end
      end
   end

   // Read data captured in setup, shown in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end else if (setup) begin
         prdata_q <= rd_mux;
      end
   end
   assign prdata = prdata_q;

   // Error detection
   // PID check bits
   wire pid_bad = pid_valid & (pid_byte[7:4] != ~pid_byte[3:0]);
   // CRC5 on tokens, CRC16 on data
   wire crc_bad = crc_valid & (crc_is_data ? (crc_rx != crc_calc) :
                  (crc_rx[4:0] != crc_calc[4:0]));
   wire [2:0] err_inc = {stuff_err_evt, pid_bad, crc_bad};

   generate
      for (genvar i = 0; i < 3; i++) begin : g_cnt
         ubt_err_cnt #(.WIDTH(ubt_pkg::UBT_CNT_W)) u_cnt (
            .pclk(pclk),
            .presetn(presetn),
            .clr(cnt_clr),
            .inc(err_inc[i]),
            .count(cnt[i])
         );
      end
   endgenerate

   // interrupt gated by own and master enables
   wire [2:0] err_en = {interrupt_enable_reg[ubt_pkg::UBT_EN_STUFF],
                        interrupt_enable_reg[ubt_pkg::UBT_EN_PID],
                        interrupt_enable_reg[ubt_pkg::UBT_EN_CRC]};
   wire irq_d = interrupt_enable_reg[ubt_pkg::UBT_EN_MST] & |(err_status_bits & err_en);

   // Token answers, error flag pulses, interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nak_q <= 1'b0;
         go_q <= 1'b0;
         flag_q <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         nak_q <= nak_d;
         go_q <= go_d;
         flag_q <= err_inc;
         irq_q <= irq_d;
      end
   end
   assign tok_nak = nak_q;
   assign tok_go = go_q;
   assign stuffing_error_flag = flag_q[2];
   assign packet_id_error_flag = flag_q[1];
   assign checksum_error_flag = flag_q[0];
   assign err_irq = irq_q;

   assign chirp_j = mode == ubt_pkg::UBT_MODE_J;
   assign chirp_k = mode == ubt_pkg::UBT_MODE_K;

   // test packet sequencer, repeats until mode changes
   always_comb begin
      tp_d = tp_q;
      tp_idx_d = tp_idx_q;
      case (tp_q)
         ubt_pkg::UBT_TP_IDLE: begin
            tp_idx_d = 9'h000;
            if (mode_pkt) begin
               tp_d = ubt_pkg::UBT_TP_FETCH;
            end
         end
         ubt_pkg::UBT_TP_FETCH: begin
            tp_d = ubt_pkg::UBT_TP_SEND;
         end
         ubt_pkg::UBT_TP_SEND: begin
            if (tx_ready) begin
               if (tp_idx_q == TP_LAST) begin
                  tp_d = ubt_pkg::UBT_TP_GAP;
                  tp_idx_d = 9'h000;
               end else begin
                  tp_d = ubt_pkg::UBT_TP_FETCH;
                  tp_idx_d = tp_idx_q + 9'h001;
               end
            end
         end
         default: begin
            tp_d = ubt_pkg::UBT_TP_FETCH;
         end
      endcase
      if (!mode_pkt) begin
         tp_d = ubt_pkg::UBT_TP_IDLE;
      end
   end

   // Sequencer state and byte register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tp_q <= ubt_pkg::UBT_TP_IDLE;
         tp_idx_q <= 9'h000;
         tx_byte_q <= 8'h00;
      end else begin
         tp_q <= tp_d;
         tp_idx_q <= tp_idx_d;
         if (tp_q == ubt_pkg::UBT_TP_FETCH) begin
            tx_byte_q <= pkt_ram_rdata;
         end
      end
   end

   // RAM read issued the cycle before FETCH, two cycles ahead of the byte being offered
   assign pkt_ram_rd = (tp_d == ubt_pkg::UBT_TP_FETCH) & (tp_q != ubt_pkg::UBT_TP_FETCH);
   assign pkt_ram_addr = TP_BASE + tp_idx_d;
   assign tx_byte = tx_byte_q;
   assign tx_valid = (tp_q == ubt_pkg::UBT_TP_SEND) & mode_pkt;
   assign tx_last = tx_valid & (tp_idx_q == TP_LAST);

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_good_token_not_ready;
      tok_good && mode_normal && !(tok_ready && dir_ok);
   endsequence
   sequence s_packet_end;
      tx_valid && tx_last && tx_ready ##1 tp_q == ubt_pkg::UBT_TP_GAP;
   endsequence

   a_nak_not_ready: assert property (s_good_token_not_ready |=> tok_nak && !tok_go)
      else $error("Unready buffer not NAKed");
   a_dir_steers_go: assert property (tok_go |-> $past(dir_ok) && $past(tok_ready))
      else $error("Proceed with wrong direction or unready buffer");
   a_ep0_single_bit: assert property (tok_good && mode_normal && tok_ep == 3'h0 && rdy_q[0]
      |=> tok_go && !tok_nak)
      else $error("Endpoint 0 buffer not shared");
   a_rdy_reserved: assert property (rdy_q[8] == 1'b0)
      else $error("Reserved ready bit set");
   a_mode_write: assert property (wr_mode |=> tm_q == $past(pwdata[2:0]))
      else $error("Test mode write lost");
   a_chirp_j_hold: assert property (tm_q == 3'h1 && !wr_mode |=> chirp_j && !chirp_k)
      else $error("Chirp J interrupted");
   a_chirp_k_hold: assert property (tm_q == 3'h2 && !wr_mode |=> chirp_k && !chirp_j)
      else $error("Chirp K interrupted");
   a_naktest_reply: assert property (mode_naktest && tok_valid && tok_is_in
      |=> tok_nak == $past(tok_crc_ok) && !tok_go)
      else $error("NAK test reply wrong");
   a_packet_repeat: assert property (s_packet_end ##1 mode_pkt |-> tp_q == ubt_pkg::UBT_TP_FETCH
      && tp_idx_q == 9'h000)
      else $error("Test packet did not restart");
   a_stuff_count: assert property (stuff_err_evt && !cnt_clr |=> cnt[2] == $past(cnt[2]) + 8'h01
      && stuffing_error_flag)
      else $error("Stuff error not counted");
   a_pid_count: assert property (pid_bad && !cnt_clr |=> cnt[1] == $past(cnt[1]) + 8'h01
      && packet_id_error_flag)
      else $error("PID error not counted");
   a_crc_count: assert property (crc_bad && !cnt_clr |=> cnt[0] == $past(cnt[0]) + 8'h01
      && checksum_error_flag)
      else $error("CRC error not counted");
   a_cnt_read_clear: assert property (cnt_rd_clr && err_inc == 3'h0 ##1 access
      |-> cnt_word == 32'h00000000 && prdata == $past(cnt_word))
      else $error("Error register not cleared by read");
   a_cnt_write_ignored: assert property (access && pwrite && hit_cnt && !cnt_clr
      && err_inc == 3'h0 |=> $stable(cnt_word))
      else $error("Error register changed by write");
   a_irq_gate: assert property (err_irq |-> $past(interrupt_enable_reg[ubt_pkg::UBT_EN_MST])
      && ($past(err_status_bits & err_en) != 3'h0))
      else $error("Interrupt without enable");
   a_undef_mode: assert property (tm_q > 3'h4 |-> !chirp_j && !chirp_k && !tx_valid)
      else $error("Undefined mode not normal");
   a_done_clears: assert property (xfer_done && !wr_rdy |=> rdy_q[$past(done_bit)] == 1'b0)
      else $error("Ready bit not cleared on completion");
endmodule // ubt_bufrdy_test

//--- testbench/ubt_host_model.sv
`timescale 1ns/10ps
module ubt_host_model #(
   parameter logic [8:0] TP_BASE = 9'h000,
   parameter int TP_LEN = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic slow,
   input wire logic [8:0] pkt_ram_addr,
   input wire logic pkt_ram_rd,
   output logic [7:0] pkt_ram_rdata,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_last,
   output logic tx_ready,
   output int n_pkts,
   output int n_bad
);
   int idx;
   // Packet RAM answers next cycle, idle cycles toggle; slow host stalls every other cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pkt_ram_rdata <= 8'h00;
         tx_ready <= 1'b0;
      end else begin
         pkt_ram_rdata <= pkt_ram_rd ? (pkt_ram_addr[7:0] ^ 8'h5C) : ~pkt_ram_rdata;
         tx_ready <= !slow || !tx_ready;
      end
   end
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx <= 0;
         n_pkts <= 0;
         n_bad <= 0;
      end else if (tx_valid && tx_ready) begin
         if (tx_byte !== ((TP_BASE[7:0] + idx[7:0]) ^ 8'h5C) || tx_last !== (idx == TP_LEN - 1))
            n_bad <= n_bad + 1;
         idx <= tx_last ? 0 : idx + 1;
         n_pkts <= n_pkts + int'(tx_last);
      end
   end
endmodule // ubt_host_model

//--- testbench/usb_dev_bufrdy_testmode_errcnt_tb.sv
`timescale 1ns/10ps
module usb_dev_bufrdy_testmode_errcnt_tb;
   localparam logic [11:0] A_RDY = 12'h114;
   localparam logic [11:0] A_MODE = 12'h118;
   localparam logic [11:0] A_CNT = 12'h11C;
   localparam logic [8:0] TPB = 9'h020;
   localparam int TPL = 6;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, slow;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, interrupt_enable_reg, rd, r;
   logic [7:0] endpoint_direction_bit, pid_byte, pkt_ram_rdata, tx_byte, cs, cp, cc;
   logic tok_valid, tok_is_in, tok_crc_ok, tok_buf, tok_nak, tok_go, xfer_done, xfer_buf;
   logic [2:0] tok_ep, xfer_ep, err_status_bits, mode, e;
   logic usb_bus_reset, stuff_err_evt, pid_valid, crc_valid, crc_is_data;
   logic [15:0] crc_rx, crc_calc, rdy;
   logic stuffing_error_flag, packet_id_error_flag, checksum_error_flag, err_irq;
   logic chirp_j, chirp_k, pkt_ram_rd, tx_valid, tx_last, tx_ready;
   logic [8:0] pkt_ram_addr;
   logic [3:0] bi;
   int mismatches, n_compared, cyc, n_pkts, n_bad, k;

   ubt_bufrdy_test #(.TP_BASE(TPB), .TP_LEN(TPL)) u_ubt_bufrdy_test (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .endpoint_direction_bit, .tok_valid, .tok_is_in, .tok_crc_ok, .tok_ep, .tok_buf,
      .tok_nak, .tok_go, .xfer_done, .xfer_ep, .xfer_buf, .usb_bus_reset, .stuff_err_evt,
      .pid_valid, .pid_byte, .crc_valid, .crc_is_data, .crc_rx, .crc_calc,
      .stuffing_error_flag, .packet_id_error_flag, .checksum_error_flag,
      .interrupt_enable_reg, .err_status_bits, .err_irq, .chirp_j, .chirp_k, .pkt_ram_addr,
      .pkt_ram_rd, .pkt_ram_rdata, .tx_byte, .tx_valid, .tx_last, .tx_ready
   );
   ubt_host_model #(.TP_BASE(TPB), .TP_LEN(TPL)) u_ubt_host_model (
      .pclk, .presetn, .slow, .pkt_ram_addr, .pkt_ram_rd, .pkt_ram_rdata, .tx_byte,
      .tx_valid, .tx_last, .tx_ready, .n_pkts, .n_bad
   );

   // Clock and hang guard
   always #10 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 10000) begin
         mismatches++;
         end_of_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Expected {nak, go} for a token under the current mode and ready bits
   function automatic logic [1:0] tok_exp(logic [2:0] ep, logic b, logic in, logic ok);
      logic [3:0] i;
      logic [2:0] m;
      i = (b && ep != 3'h0) ? {1'b1, ep} : {1'b0, ep};
      m = (mode > 3'h4) ? 3'h0 : mode;
      if (!ok || m == 3'h1 || m == 3'h2 || m == 3'h4) return 2'b00;
      if (m == 3'h3) return {in, 1'b0};
      if (!rdy[i] || (ep != 3'h0 && endpoint_direction_bit[ep] != in)) return 2'b10;
      return 2'b01;
   endfunction
   task automatic tok(input logic [31:0] t);
      tok_valid <= 1'b1;
      tok_ep <= t[2:0];
      tok_buf <= t[3];
      tok_is_in <= t[4];
      tok_crc_ok <= t[5] | t[6];
      @(posedge pclk);
      tok_valid <= 1'b0;
      #1 check({30'h0, tok_nak, tok_go}, {30'h0, tok_exp(t[2:0], t[3], t[4], t[5] | t[6])}, "token");
      @(posedge pclk);
   endtask

   initial begin
      pclk = 0;
      presetn = 0;
      {psel, penable, pwrite, paddr, pwdata, tok_valid, tok_is_in, tok_crc_ok, tok_ep} = '0;
      {tok_buf, xfer_done, xfer_ep, xfer_buf, usb_bus_reset, stuff_err_evt, pid_valid} = '0;
      {pid_byte, crc_valid, crc_is_data, crc_rx, crc_calc, interrupt_enable_reg} = '0;
      {err_status_bits, endpoint_direction_bit, mismatches, n_compared, cyc} = '0;
      slow = 1;
      void'($urandom(32'hE71990DA));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, A_RDY, 0); check(rd, 0, "ready reset");
      apb(1'b0, A_MODE, 0); check(rd, 0, "mode reset");
      apb(1'b0, A_CNT, 0); check(rd, 0, "count reset");
      apb(1'b1, 12'h200, 32'h5A5A5A5A); check({rd[30:0], er}, 1, "unmapped");
      $display("reset and map test done");
      // Arming, completion and tokens in normal mode
      rdy = 16'h0;
      mode = 3'h0;
      repeat (40) begin
         r = $urandom;
         endpoint_direction_bit <= r[31:24];
         if (r[17:16] == 2'h0) begin
            apb(1'b1, A_RDY, r);
            rdy = r[15:0] & 16'hFEFF;
         end else if (r[17:16] == 2'h1) begin
            xfer_done <= 1'b1;
            xfer_ep <= r[22:20];
            xfer_buf <= r[23];
            bi = (r[23] && r[22:20] != 3'h0) ? {1'b1, r[22:20]} : {1'b0, r[22:20]};
            @(posedge pclk);
            xfer_done <= 1'b0;
            rdy[bi] = 1'b0;
         end
         apb(1'b0, A_RDY, 0); check(rd, {16'h0, rdy}, "ready readback");
         tok($urandom);
      end
      $display("ready and token test done");
      // Every mode code, undefined ones included
      for (int m = 0; m < 8; m++) begin
         mode = 3'(m);
         apb(1'b1, A_MODE, {29'h1FFFFFFF, mode});
         apb(1'b0, A_MODE, 0); check(rd, {29'h0, mode}, "mode readback");
         repeat (100) @(posedge pclk);
         check({chirp_j, chirp_k}, {mode == 3'h1, mode == 3'h2}, "chirp");
         repeat (4) tok($urandom);
         if (mode == 3'h4) check(32'(n_pkts >= 2 && n_bad == 0), 1, "test packet");
      end
      apb(1'b1, A_MODE, 0);
      mode = 3'h0;
      $display("mode test done");
      // Error events of all kinds, good and bad
      apb(1'b0, A_CNT, 0);
      {cs, cp, cc} = '0;
      repeat (60) begin
         r = $urandom;
         k = int'(r[23:22]) % 3;
         case (k)
            0: stuff_err_evt <= 1'b1;
            1: begin
               pid_valid <= 1'b1;
               pid_byte <= {~r[3:0] ^ {3'h0, r[20]}, r[3:0]};
            end
            default: begin
               crc_valid <= 1'b1;
               crc_is_data <= r[21];
               crc_rx <= r[15:0];
               crc_calc <= r[15:0] ^ (r[21] ? {r[20], 15'h0} : {10'h0, !r[20], 4'h0, r[20]});
            end
         endcase
         e = (k == 0 || r[20]) ? 3'h4 >> k : 3'h0;
         @(posedge pclk);
         {stuff_err_evt, pid_valid, crc_valid} <= 3'h0;
         #1 check({stuffing_error_flag, packet_id_error_flag, checksum_error_flag}, e, "flags");
         {cs, cp, cc} = {cs + 8'(e[2]), cp + 8'(e[1]), cc + 8'(e[0])};
         @(posedge pclk);
      end
      apb(1'b0, A_CNT, 0); check(rd, {8'h0, cs, cp, cc}, "counts");
      apb(1'b0, A_CNT, 0); check(rd, 0, "read clear");
      repeat (258) begin
         stuff_err_evt <= 1'b1;
         @(posedge pclk);
         stuff_err_evt <= 1'b0;
         @(posedge pclk);
      end
      apb(1'b1, A_CNT, 32'hFFFFFFFF);
      apb(1'b0, A_CNT, 0); check(rd, 32'h00020000, "wrap, write");
      pid_valid <= 1'b1;
      pid_byte <= 8'h11;
      @(posedge pclk);
      pid_valid <= 1'b0;
      usb_bus_reset <= 1'b1;
      @(posedge pclk);
      usb_bus_reset <= 1'b0;
      @(posedge pclk);
      apb(1'b0, A_CNT, 0); check(rd, 0, "bus reset clear");
      $display("error counter test done");
      // Interrupt gating by own and master enables
      repeat (30) begin
         r = $urandom;
         interrupt_enable_reg <= r;
         err_status_bits <= r[2:0];
         repeat (2) @(posedge pclk);
         #1 check({31'h0, err_irq}, {31'h0, r[31] & |(r[2:0] & r[29:27])}, "irq");
         @(posedge pclk);
      end
      $display("interrupt test done");
      end_of_test();
   end
endmodule // usb_dev_bufrdy_testmode_errcnt_tb
